// ### hw/pcs_regs.vh
/*
 register offsets, field positions, reset values for the profiling counter set.
 assumes byte addressing on a plain register port with 32-bit data.
*/
`ifndef PCS_REGS_VH
`define PCS_REGS_VH

`define PCS_ADDR_W 8
`define PCS_OFF_CTRL 8'h00
`define PCS_OFF_CYC 8'h04
`define PCS_OFF_INSTR 8'h08
`define PCS_OFF_EXC 8'h0c
`define PCS_OFF_SLEEP 8'h10
`define PCS_OFF_LSU 8'h14
`define PCS_OFF_FOLD 8'h18
`define PCS_OFF_PCS 8'h1c
`define PCS_OFF_OVF 8'h20

`define PCS_CTRL_CYC_EN 0
`define PCS_CTRL_INSTR_EV 17
`define PCS_CTRL_EXC_EV 18
`define PCS_CTRL_SLEEP_EV 19
`define PCS_CTRL_LSU_EV 20
`define PCS_CTRL_FOLD_EV 21
`define PCS_CTRL_NOPRF 24
`define PCS_CTRL_NOCYC 25

`define PCS_CTRL_RST 32'h00000000
`define PCS_CNT8_RST 8'h00
`define PCS_CYC_RST 32'h00000000
`define PCS_NUM_PRF 5

`endif

// ### hw/pcs_core.v
/*
 profiling counter set: 32-bit cycle counter, five 8-bit event counters,
 program counter sampler, and their register port.
 assumes core status inputs are on the same clock, one level per cycle.
*/
// Notes on behaviour
// - cycle counter adds one each clock while enabled; software reads and writes it
// - cycle counter wraps from all ones to zero and keeps counting
// - cycle counter holds while core is halted in debug state
// - without cycle counter its register reads zero and ignores writes
// - software reads and sets the cycle counter through its register
// - setting a counter's event enable from zero to one clears that counter
// - without profiling counters their registers read zero and ignore writes
// - instruction overhead counts extra multi-cycle cycles not load/store, plus fetch stalls
// - exception counter counts every exception processing cycle
// - sleep counter counts sleeping cycles
// - sleep counter counts any sleep, whatever the cause of entry
// - load/store counter counts extra load/store cycles
// - folded counter counts each zero-cycle instruction
// - without folding support folded counter reads zero, ignores writes
// - pc sample register returns an executed instruction address
// - bit 0 of each pc sample reads zero
// - absent sampler reads zero and ignores writes
// - cycle counter enable resets to zero; one lets it count
`timescale 1ns/100ps
`include "pcs_regs.vh"

module pcs_core #(
    parameter HAS_CYC = 1,
    parameter HAS_PRF = 1,
    parameter HAS_FOLD = 1,
    parameter HAS_PCS = 1
) (
    input wire clock,
    input wire srst,
    input wire [`PCS_ADDR_W-1:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    input wire core_halted,
    input wire core_instr_extra,
    input wire core_fetch_stall,
    input wire core_exception,
    input wire core_sleeping,
    input wire core_lsu_extra,
    input wire core_folded,
    input wire core_retire,
    input wire [31:0] core_retire_addr,
    output reg [`PCS_NUM_PRF-1:0] ovf_event
);

    // feature switches
    localparam [0:0] CYC_ON = (HAS_CYC != 0);
    localparam [0:0] PRF_ON = (HAS_PRF != 0);
    localparam [0:0] FOLD_ON = (HAS_FOLD != 0);
    localparam [0:0] PCS_ON = (HAS_PCS != 0);

    // constants
    localparam [7:0] CNT_ONE = 8'h01;
    localparam [31:0] CYC_ONE = 32'h00000001;
    localparam [31:0] ZERO_WORD = 32'h00000000;

    // control register state
    reg cyc_en_q;
    reg cyc_en_d;
    reg [`PCS_NUM_PRF-1:0] ev_en_q;
    reg [`PCS_NUM_PRF-1:0] ev_en_d;

    // cycle counter state
    reg [31:0] cyc_q;
    reg [31:0] cyc_d;

    // overflow state
    reg [`PCS_NUM_PRF-1:0] ovf_sticky_q;
    reg [`PCS_NUM_PRF-1:0] ovf_sticky_d;
    reg [`PCS_NUM_PRF-1:0] ovf_event_d;

    // pc sampler state
    reg [31:0] pcs_q;
    reg [31:0] pcs_d;

    // read path
    reg [31:0] rdata_d;
    reg [31:0] rdata_next;

    // per counter strobes
    wire [`PCS_NUM_PRF-1:0] cnt_inc;
    wire [`PCS_NUM_PRF-1:0] cnt_wr;
    wire [`PCS_NUM_PRF-1:0] cnt_clr;
    wire [`PCS_NUM_PRF-1:0] cnt_wrap;
    wire [`PCS_NUM_PRF-1:0] cnt_live;
    wire [`PCS_NUM_PRF-1:0] ev_wr_val;
    wire [`PCS_NUM_PRF-1:0] ovf_hit;
    wire [8*`PCS_NUM_PRF-1:0] cnt_flat;

    // address decode
    wire hit_ctrl;
    wire hit_cyc;
    wire hit_ovf;

    // decoded accesses
    wire ctrl_wr;
    wire cyc_wr;
    wire ovf_rd;

    assign hit_ctrl = (reg_addr == `PCS_OFF_CTRL);
    assign hit_cyc = (reg_addr == `PCS_OFF_CYC);
    assign hit_ovf = (reg_addr == `PCS_OFF_OVF);

    assign ctrl_wr = reg_wr && hit_ctrl;
    assign cyc_wr = reg_wr && hit_cyc;
    assign ovf_rd = reg_rd && hit_ovf;
    assign ev_wr_val = reg_wdata[`PCS_CTRL_FOLD_EV:`PCS_CTRL_INSTR_EV];

    // event sources per counter
    assign cnt_inc[0] = (core_instr_extra && !core_lsu_extra) || core_fetch_stall;
    assign cnt_inc[1] = core_exception;
    assign cnt_inc[2] = core_sleeping;
    assign cnt_inc[3] = core_lsu_extra;
    assign cnt_inc[4] = core_folded && FOLD_ON;

    // cycle enable next value
    always @* begin
        cyc_en_d = cyc_en_q;
        if (ctrl_wr) begin
            cyc_en_d = reg_wdata[`PCS_CTRL_CYC_EN] && CYC_ON;
        end
    end

    // event enables next value
    always @* begin
        ev_en_d = ev_en_q;
        if (ctrl_wr) begin
            ev_en_d = ev_wr_val & {`PCS_NUM_PRF{PRF_ON}};
        end
    end

    // cycle enable flop
    always @(posedge clock) begin
        if (srst) begin
            cyc_en_q <= 1'b0;
        end else begin
            cyc_en_q <= cyc_en_d;
        end
    end

    // event enable flops
    always @(posedge clock) begin
        if (srst) begin
            ev_en_q <= {`PCS_NUM_PRF{1'b0}};
        end else begin
            ev_en_q <= ev_en_d;
        end
    end

    // cycle counter: a software write wins over the increment
    always @* begin
        cyc_d = cyc_q;
        if (!CYC_ON) begin
            cyc_d = `PCS_CYC_RST;
        end else if (cyc_wr) begin
            cyc_d = reg_wdata;
        end else if (cyc_en_q && !core_halted) begin
            cyc_d = cyc_q + CYC_ONE;
        end
    end

    // cycle counter flops
    always @(posedge clock) begin
        if (srst) begin
            cyc_q <= `PCS_CYC_RST;
        end else begin
            cyc_q <= cyc_d;
        end
    end

    // five 8-bit profiling counters
    genvar i;
    generate
        for (i = 0; i < `PCS_NUM_PRF; i = i + 1) begin : g_cnt
            localparam integer CNT_OFF_I = `PCS_OFF_INSTR + 4 * i;
            localparam [7:0] CNT_OFF = CNT_OFF_I[7:0];

            reg [7:0] cnt_q;
            reg [7:0] cnt_d;
            wire [7:0] cnt_view;

            assign cnt_live[i] = PRF_ON && (i != 4 || FOLD_ON);
            assign cnt_wr[i] = reg_wr && (reg_addr == CNT_OFF);
            assign cnt_clr[i] = ctrl_wr && ev_wr_val[i] && !ev_en_q[i];
            assign cnt_wrap[i] = cnt_inc[i] && (cnt_q == 8'hff);
            assign ovf_hit[i] = cnt_wrap[i] && ev_en_q[i] && !cnt_clr[i] && !cnt_wr[i];
            assign cnt_view = cnt_live[i] ? cnt_q : 8'h00;
            assign cnt_flat[8*i+7:8*i] = cnt_view;

            // priority: enable-set clear, then write, then increment
            always @* begin
                cnt_d = cnt_q;
                if (!cnt_live[i]) begin
                    cnt_d = `PCS_CNT8_RST;
                end else if (cnt_clr[i]) begin
                    cnt_d = 8'h00;
                end else if (cnt_wr[i]) begin
                    cnt_d = reg_wdata[7:0];
                end else if (cnt_inc[i]) begin
                    cnt_d = cnt_q + CNT_ONE;
                end
            end

            // counter flops
            always @(posedge clock) begin
                if (srst) begin
                    cnt_q <= `PCS_CNT8_RST;
                end else begin
                    cnt_q <= cnt_d;
                end
            end
        end
    endgenerate

    // overflow pulse next value
    always @* begin
        ovf_event_d = ovf_hit;
    end

    // sticky next value; a wrap in the clearing read wins
    always @* begin
        if (ovf_rd) begin
            ovf_sticky_d = ovf_hit;
        end else begin
            ovf_sticky_d = ovf_sticky_q | ovf_hit;
        end
    end

    // overflow pulse flop
    always @(posedge clock) begin
        if (srst) begin
            ovf_event <= {`PCS_NUM_PRF{1'b0}};
        end else begin
            ovf_event <= ovf_event_d;
        end
    end

    // sticky flops
    always @(posedge clock) begin
        if (srst) begin
            ovf_sticky_q <= {`PCS_NUM_PRF{1'b0}};
        end else begin
            ovf_sticky_q <= ovf_sticky_d;
        end
    end

    // pc sampler: latest retired address, bit 0 forced low
    always @* begin
        pcs_d = pcs_q;
        if (!PCS_ON) begin
            pcs_d = ZERO_WORD;
        end else if (core_retire) begin
            pcs_d = {core_retire_addr[31:1], 1'b0};
        end
    end

    // pc sampler flops
    always @(posedge clock) begin
        if (srst) begin
            pcs_q <= ZERO_WORD;
        end else begin
            pcs_q <= pcs_d;
        end
    end

    // read multiplexer
    always @* begin
        rdata_d = ZERO_WORD;
        case (reg_addr)
            `PCS_OFF_CTRL: begin
                rdata_d[`PCS_CTRL_CYC_EN] = cyc_en_q;
                rdata_d[`PCS_CTRL_FOLD_EV:`PCS_CTRL_INSTR_EV] = ev_en_q;
                rdata_d[`PCS_CTRL_NOPRF] = !PRF_ON;
                rdata_d[`PCS_CTRL_NOCYC] = !CYC_ON;
            end

            `PCS_OFF_CYC: begin
                rdata_d = cyc_q;
            end

            `PCS_OFF_INSTR: begin
                rdata_d[7:0] = cnt_flat[7:0];
            end

            `PCS_OFF_EXC: begin
                rdata_d[7:0] = cnt_flat[15:8];
            end

            `PCS_OFF_SLEEP: begin
                rdata_d[7:0] = cnt_flat[23:16];
            end

            `PCS_OFF_LSU: begin
                rdata_d[7:0] = cnt_flat[31:24];
            end

            `PCS_OFF_FOLD: begin
                rdata_d[7:0] = cnt_flat[39:32];
            end

            `PCS_OFF_PCS: begin
                rdata_d = pcs_q;
            end

            `PCS_OFF_OVF: begin
                rdata_d[`PCS_NUM_PRF-1:0] = ovf_sticky_q;
            end

            default: begin
                rdata_d = ZERO_WORD;
            end
        endcase
    end

    // read data only in the cycle after the strobe, zero otherwise
    always @* begin
        rdata_next = ZERO_WORD;
        if (reg_rd) begin
            rdata_next = rdata_d;
        end
    end

    // read data flop
    always @(posedge clock) begin
        if (srst) begin
            reg_rdata <= ZERO_WORD;
        end else begin
            reg_rdata <= rdata_next;
        end
    end

endmodule // pcs_core

// ### tb/pcs_assertions.sv
/* checker on the profiling counter set ports
 assumes bind into pcs_core, one clock, srst synchronous */
`timescale 1ns/100ps
module pcs_assertions (
    input wire clock,
    input wire srst,
    input wire [7:0] reg_addr,
    input wire reg_rd,
    input wire [31:0] reg_rdata,
    input wire core_instr_extra,
    input wire core_fetch_stall,
    input wire core_exception,
    input wire core_sleeping,
    input wire core_lsu_extra,
    input wire core_folded,
    input wire [4:0] ovf_event
);
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    a_pc_bit0: assert property ($past(reg_rd && reg_addr == 8'h1c) |-> !reg_rdata[0])
        else $error("pc sample bit0 set");
    a_hi_zero: assert property ($past(reg_rd && reg_addr >= 8'h08 && reg_addr <= 8'h18)
        |-> reg_rdata[31:8] == 24'h0) else $error("counter upper bits set");
    a_ovf_single: assert property ((ovf_event & $past(ovf_event)) == 5'h00)
        else $error("overflow pulse too long");
    a_instr_cause: assert property (ovf_event[0] |-> $past(core_fetch_stall
        || core_instr_extra && !core_lsu_extra)) else $error("instr wrap without cause");
    a_exc_cause: assert property (ovf_event[1] |-> $past(core_exception))
        else $error("exc wrap without cause");
    a_sleep_cause: assert property (ovf_event[2] |-> $past(core_sleeping))
        else $error("sleep wrap without cause");
    a_lsu_cause: assert property (ovf_event[3] |-> $past(core_lsu_extra))
        else $error("lsu wrap without cause");
    a_fold_cause: assert property (ovf_event[4] |-> $past(core_folded))
        else $error("fold wrap without cause");
endmodule // pcs_assertions
bind pcs_core pcs_assertions u_pcs_assertions (.*);

// ### tb/pcs_core_model.sv
/* core side model: random per-cycle status while run is high
 assumes same clock as the counter set */
`timescale 1ns/100ps
module pcs_core_model (
    input wire clock,
    input wire run,
    output logic [7:0] st,
    output logic [31:0] addr
);
    initial st = 8'h00;
    initial addr = 32'h0;
    always @(posedge clock) begin
        st <= run ? 8'($urandom) : 8'h00;
        addr <= $urandom;
    end
endmodule // pcs_core_model

// ### tb/pcs_core_bench.sv
/* bench for pcs_core: random core traffic, reads checked against a model
 checks design defaults (all features present) beside a bare instance with all features off */
`timescale 1ns/100ps
module pcs_core_bench;
    logic clock, srst, reg_wr, reg_rd, run;
    logic [7:0] reg_addr, st;
    logic [31:0] reg_wdata, reg_rdata, addr, ctl, cyc, pcs;
    logic [4:0] ovf_event, inc, eo, ovf_b;
    logic [31:0] rdata_b;
    logic rq;
    logic [7:0] c [5];
    int error_cnt, comparisons;
    pcs_core u_pcs_core (.clock(clock), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .core_halted(st[6]), .core_instr_extra(st[0]), .core_fetch_stall(st[7]),
        .core_exception(st[1]), .core_sleeping(st[2]), .core_lsu_extra(st[3]),
        .core_folded(st[4]), .core_retire(st[5]), .core_retire_addr(addr),
        .ovf_event(ovf_event));
    pcs_core_model u_pcs_core_model (.clock(clock), .run(run), .st(st), .addr(addr));
    pcs_core #(.HAS_CYC(0), .HAS_PRF(0), .HAS_FOLD(0), .HAS_PCS(0)) u_pcs_core_bare (
        .clock(clock), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata_b),
        .core_halted(st[6]), .core_instr_extra(st[0]), .core_fetch_stall(st[7]),
        .core_exception(st[1]), .core_sleeping(st[2]), .core_lsu_extra(st[3]),
        .core_folded(st[4]), .core_retire(st[5]), .core_retire_addr(addr),
        .ovf_event(ovf_b));
    always @(negedge clock) begin
        if (!srst) chk({27'h0, ovf_event | ovf_b}, {27'h0, eo});
        if (!srst && !rq) chk(reg_rdata | rdata_b, 32'h0);
    end
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    assign inc = {st[4:1], st[0] & ~st[3] | st[7]};
    always @(posedge clock) begin
        for (int i = 0; i < 5; i++) begin
            c[i] <= srst || reg_wr && reg_addr == 8'h00 && reg_wdata[17 + i] && !ctl[17 + i]
                ? 8'h00 : reg_wr && reg_addr == 8'(8 + 4 * i) ? reg_wdata[7:0]
                : c[i] + inc[i];
            eo[i] <= !srst && inc[i] && c[i] == 8'hff && ctl[17 + i]
                && !(reg_wr && (reg_addr == 8'h00 && reg_wdata[17 + i] && !ctl[17 + i]
                || reg_addr == 8'(8 + 4 * i)));
        end
        rq <= reg_rd;
        cyc <= srst ? 32'h0 : reg_wr && reg_addr == 8'h04 ? reg_wdata
            : cyc + (ctl[0] & ~st[6]);
        ctl <= srst ? 32'h0 : reg_wr && reg_addr == 8'h00 ? reg_wdata : ctl;
        pcs <= srst ? 32'h0 : st[5] ? addr & ~32'h1 : pcs;
    end
    function automatic logic [31:0] expv(input logic [7:0] a);
        if (a == 8'h00) return ctl & 32'h003e0001;
        if (a == 8'h04) return cyc;
        if (a == 8'h1c) return pcs;
        if (a >= 8'h08 && a <= 8'h18) return {24'h0, c[(a - 8'h08) >> 2]};
        return 32'h0;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t read %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        logic [31:0] e;
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        e = expv(a);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
        chk(rdata_b, a == 8'h00 ? 32'h03000000 : 32'h0);
    endtask
    task automatic report_and_stop;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        {srst, run, reg_wr, reg_rd, reg_addr, reg_wdata} = {4'b1000, 40'h0};
        void'($urandom(32'h2901));
        repeat (8) @(posedge clock);
        srst <= 1'b0;
        for (int a = 0; a <= 36; a += 4) rd(8'(a));
        for (int k = 0; k < 2; k++) begin
            for (int a = 8; a <= 24; a += 4) begin
                wr(8'(a), $urandom);
                rd(8'(a));
            end
            wr(8'h04, 32'hffffffc0);
            wr(8'h00, 32'h003e0001);
            run <= 1'b1;
            repeat (80) rd(8'(4 + 4 * ($urandom % 7)));
            run <= 1'b0;
            for (int a = 0; a <= 28; a += 4) rd(8'(a));
            wr(8'h00, 32'h00000001);
        end
        report_and_stop();
    end
endmodule // pcs_core_bench
